/* core/mrsc_top.sv */
// run-control and status command interpreter
// Functional notes
// - freeze command 1 halts measurement updates, 0 resumes them
// - freeze query replies 1 while frozen, else 0
// - accumulation run 0 stops; 1 clears data, restarts, launches start delay
// - accumulation query: 0 idle, 1 delay, 2 held by freeze, 3 updating
// - flag word read returns all set bits then clears them
// - bits 8-10 analyzer harmonic done, bit 16 spectrum done
// - commit with a configuration change clears the whole flag word
// - capture command: 0 stop, 1 single, 2 continuous
// - starting any capture first discards old captured data
// - capture query codes 0..4 for stop/single/continuous with or without data
// - standby run on selected analyzer: 0 stops, 1 starts
// - standby query idle codes: 0 never run, 1 operator stop, 2 normal end
// - standby running codes: 3 waiting, 4 minimum, 5 extended, 6 alternate
// - ten user configuration stores hold the saveable settings
// - save and recall leave power, interface, time format settings alone
// - factory store can be recalled but never saved into
// - save copies configuration into user store 1 to 10
`timescale 1ns/1ps
`default_nettype none
module mrsc_top
   import mrsc_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic cmd_valid,
   output logic cmd_ready,
   input wire logic [3:0] cmd_code,
   input wire logic [3:0] cmd_arg,
   input wire logic [1:0] cmd_sel,
   input wire logic [CFG_W-1:0] cfg_edit,
   output logic cmd_err,
   output logic rsp_valid,
   input wire logic rsp_ready,
   output logic [7:0] rsp_data,
   input wire logic [NVPA-1:0] ev_nonharm_done,
   input wire logic ev_motor_done,
   input wire logic [NVPA-1:0] ev_harm_done,
   input wire logic ev_spectrum_done,
   output logic meas_frozen,
   input wire logic [15:0] acc_delay_cyc,
   output logic acc_clear,
   output logic acc_updating,
   input wire logic scope_captured,
   output logic scope_discard,
   output logic scope_running,
   input wire logic [NVPA-1:0] stby_alt_method,
   input wire logic [NVPA-1:0] stby_level_seen,
   input wire logic [NVPA-1:0] stby_min_elapsed,
   input wire logic [NVPA-1:0] stby_finished,
   output logic [NVPA-1:0] stby_active,
   output logic [CFG_W-1:0] cfg_active
);
   logic take;
   logic fmt_idle;
   logic fmt_start;
   logic [31:0] fmt_value;
   logic is_query;
   logic arg_bad;
   logic sel_ok;
   logic recall_busy_ff;
   logic freeze_ff;
   mrsc_acc_t acc_ff;
   logic [15:0] acc_cnt_ff;
   mrsc_scope_t sc_ff;
   logic sc_data_ff;
   mrsc_sb_t sb_ff [NVPA];
   logic [31:0] flags_ff;
   logic [31:0] nxt_flags;
   logic [31:0] flag_set;
   logic cfg_changed;
   logic [CFG_W-1:0] cfg_ff;
   logic [CFG_W-1:0] st_rdata;
   logic st_ok;
   logic st_err;
   logic err_ff;
   logic acc_clear_ff;
   logic scope_discard_ff;

   assign cmd_ready = fmt_idle && !recall_busy_ff;
   assign take = cmd_valid && cmd_ready;
   assign sel_ok = cmd_sel < 2'(NVPA);
   assign cmd_err = err_ff;
   assign meas_frozen = freeze_ff;
   assign acc_clear = acc_clear_ff;
   assign acc_updating = (acc_ff == ACC_RUN) && !freeze_ff;
   assign scope_discard = scope_discard_ff;
   assign scope_running = (sc_ff != SC_STOP);
   assign cfg_active = cfg_ff;
   assign cfg_changed = cfg_edit != cfg_ff;

   always_comb
   begin
      for (int i = 0; i < NVPA; i++)
         stby_active[i] = (sb_ff[i] == SB_WAIT) || (sb_ff[i] == SB_MIN)
            || (sb_ff[i] == SB_EXT) || (sb_ff[i] == SB_ALT);
   end

   // argument range check per command
   always_comb
   begin
      is_query = 1'b0;
      arg_bad = 1'b0;
      unique case (cmd_code)
         CMD_FREEZE_Q, CMD_ACC_Q, CMD_FLAG_RD, CMD_SCOPE_Q: is_query = 1'b1;
         CMD_STBY_Q:
         begin
            is_query = sel_ok;
            arg_bad = !sel_ok;
         end
         CMD_FREEZE, CMD_ACC_RUN: arg_bad = cmd_arg > 4'h1;
         CMD_SCOPE: arg_bad = cmd_arg > 4'h2;
         CMD_STBY_RUN: arg_bad = (cmd_arg > 4'h1) || !sel_ok;
         CMD_COMMIT, CMD_SAVE, CMD_RECALL: arg_bad = 1'b0;
         default: arg_bad = 1'b1;
      endcase
   end

   // reply value for each query
   always_comb
   begin
      fmt_value = 32'h0;
      unique case (cmd_code)
         CMD_FREEZE_Q: fmt_value = {31'h0, freeze_ff};
         CMD_ACC_Q:
            unique case (acc_ff)
               ACC_IDLE: fmt_value = ACC_C_IDLE;
               ACC_WAIT: fmt_value = ACC_C_WAIT;
               ACC_RUN: fmt_value = freeze_ff ? ACC_C_HELD : ACC_C_RUN;
               default: fmt_value = ACC_C_IDLE;
            endcase
         CMD_FLAG_RD: fmt_value = flags_ff;
         CMD_SCOPE_Q:
            unique case (sc_ff)
               SC_STOP: fmt_value = sc_data_ff ? SC_C_STOP_DATA : SC_C_STOP_EMPTY;
               SC_SINGLE: fmt_value = SC_C_SINGLE;
               SC_CONT: fmt_value = sc_data_ff ? SC_C_CONT_DATA : SC_C_CONT_EMPTY;
               default: fmt_value = SC_C_STOP_EMPTY;
            endcase
         CMD_STBY_Q:
            if (sel_ok)
               unique case (sb_ff[cmd_sel])
                  SB_NONE: fmt_value = SB_C_NONE;
                  SB_USER: fmt_value = SB_C_USER;
                  SB_NORM: fmt_value = SB_C_NORM;
                  SB_WAIT: fmt_value = SB_C_WAIT;
                  SB_MIN: fmt_value = SB_C_MIN;
                  SB_EXT: fmt_value = SB_C_EXT;
                  SB_ALT: fmt_value = SB_C_ALT;
                  default: fmt_value = SB_C_NONE;
               endcase
         default: fmt_value = 32'h0;
      endcase
   end

   assign fmt_start = take && is_query;

   mrsc_reply_fmt u_fmt (
      .clk_sys(clk_sys),
      .rstn(rstn),
      .start(fmt_start),
      .value(fmt_value),
      .idle(fmt_idle),
      .rsp_valid(rsp_valid),
      .rsp_ready(rsp_ready),
      .rsp_data(rsp_data)
   );

   mrsc_cfg_store u_store (
      .clk_sys(clk_sys),
      .rstn(rstn),
      .save_req(take && cmd_code == CMD_SAVE),
      .recall_req(take && cmd_code == CMD_RECALL),
      .idx(cmd_arg),
      .wdata(cfg_ff),
      .rdata(st_rdata),
      .rd_ok(st_ok),
      .op_err(st_err)
   );

   // error pulse and recall wait
   always_ff @(posedge clk_sys)
   begin
      if (!rstn)
      begin
         err_ff <= 1'b0;
         recall_busy_ff <= 1'b0;
      end
      else
      begin
         err_ff <= (take && arg_bad) || st_err;
         recall_busy_ff <= take && cmd_code == CMD_RECALL;
      end
   end

   // active configuration
   always_ff @(posedge clk_sys)
   begin
      if (!rstn)
         cfg_ff <= CFG_FACTORY;
      else if (st_ok)
         cfg_ff <= (st_rdata & ~CFG_KEEP_MASK) | (cfg_ff & CFG_KEEP_MASK);
      else if (take && cmd_code == CMD_COMMIT)
         cfg_ff <= cfg_edit;
   end

   // freeze
   always_ff @(posedge clk_sys)
   begin
      if (!rstn)
         freeze_ff <= 1'b0;
      else if (take && cmd_code == CMD_FREEZE && !arg_bad)
         freeze_ff <= cmd_arg[0];
   end

   // completion flags, a new event wins over the clear
   always_comb
   begin
      flag_set = 32'h0;
      flag_set[FLG_NONHARM_LSB +: NVPA] = ev_nonharm_done;
      flag_set[FLG_MOTOR] = ev_motor_done;
      flag_set[FLG_HARM_LSB +: NVPA] = ev_harm_done;
      flag_set[FLG_SPECTRUM] = ev_spectrum_done;
      nxt_flags = flags_ff;
      if (take && cmd_code == CMD_FLAG_RD)
         nxt_flags = FLAGS_RESET;
      if (take && cmd_code == CMD_COMMIT && cfg_changed)
         nxt_flags = FLAGS_RESET;
      nxt_flags = nxt_flags | flag_set;
   end

   always_ff @(posedge clk_sys)
   begin
      if (!rstn)
         flags_ff <= FLAGS_RESET;
      else
         flags_ff <= nxt_flags;
   end

   // accumulation run control
   always_ff @(posedge clk_sys)
   begin
      if (!rstn)
      begin
         acc_ff <= ACC_IDLE;
         acc_cnt_ff <= 16'h0;
         acc_clear_ff <= 1'b0;
      end
      else
      begin
         acc_clear_ff <= 1'b0;
         if (take && cmd_code == CMD_ACC_RUN && !arg_bad)
         begin
            if (cmd_arg[0])
            begin
               acc_clear_ff <= 1'b1;
               acc_cnt_ff <= acc_delay_cyc;
               acc_ff <= (acc_delay_cyc == 16'h0) ? ACC_RUN : ACC_WAIT;
            end
            else
               acc_ff <= ACC_IDLE;
         end
         else if (acc_ff == ACC_WAIT)
         begin
            acc_cnt_ff <= acc_cnt_ff - 16'h1;
            if (acc_cnt_ff == 16'h1)
               acc_ff <= ACC_RUN;
         end
      end
   end

   // waveform capture control
   always_ff @(posedge clk_sys)
   begin
      if (!rstn)
      begin
         sc_ff <= SC_STOP;
         sc_data_ff <= 1'b0;
         scope_discard_ff <= 1'b0;
      end
      else
      begin
         scope_discard_ff <= 1'b0;
         if (take && cmd_code == CMD_SCOPE && !arg_bad)
         begin
            if (cmd_arg == 4'h0)
               sc_ff <= SC_STOP;
            else
            begin
               sc_ff <= cmd_arg[1] ? SC_CONT : SC_SINGLE;
               sc_data_ff <= 1'b0;
               scope_discard_ff <= 1'b1;
            end
         end
         else if (scope_captured && sc_ff != SC_STOP)
         begin
            sc_data_ff <= 1'b1;
            if (sc_ff == SC_SINGLE)
               sc_ff <= SC_STOP;
         end
      end
   end

   // standby run state per analyzer
   always_ff @(posedge clk_sys)
   begin
      if (!rstn)
      begin
         for (int i = 0; i < NVPA; i++)
            sb_ff[i] <= SB_NONE;
      end
      else
      begin
         for (int i = 0; i < NVPA; i++)
         begin
            if (take && cmd_code == CMD_STBY_RUN && !arg_bad && cmd_sel == 2'(i))
            begin
               if (cmd_arg[0])
                  sb_ff[i] <= stby_alt_method[i] ? SB_WAIT : SB_MIN;
               else if (stby_active[i])
                  sb_ff[i] <= SB_USER;
            end
            else
               unique case (sb_ff[i])
                  SB_WAIT: if (stby_level_seen[i]) sb_ff[i] <= SB_ALT;
                  SB_MIN: if (stby_min_elapsed[i]) sb_ff[i] <= SB_EXT;
                  SB_EXT, SB_ALT: if (stby_finished[i]) sb_ff[i] <= SB_NORM;
                  SB_NONE, SB_USER, SB_NORM: sb_ff[i] <= sb_ff[i];
                  default: sb_ff[i] <= SB_NONE;
               endcase
         end
      end
   end
endmodule : mrsc_top
`default_nettype wire

/* include/mrsc_pkg.sv */
// shared constants and types for the run/status command block
package mrsc_pkg;
   // command codes on the decoded command port
   localparam logic [3:0] CMD_FREEZE = 4'h0;
   localparam logic [3:0] CMD_FREEZE_Q = 4'h1;
   localparam logic [3:0] CMD_ACC_RUN = 4'h2;
   localparam logic [3:0] CMD_ACC_Q = 4'h3;
   localparam logic [3:0] CMD_FLAG_RD = 4'h4;
   localparam logic [3:0] CMD_SCOPE = 4'h5;
   localparam logic [3:0] CMD_SCOPE_Q = 4'h6;
   localparam logic [3:0] CMD_STBY_RUN = 4'h7;
   localparam logic [3:0] CMD_STBY_Q = 4'h8;
   localparam logic [3:0] CMD_COMMIT = 4'h9;
   localparam logic [3:0] CMD_SAVE = 4'ha;
   localparam logic [3:0] CMD_RECALL = 4'hb;
   localparam int NVPA = 3;
   localparam int CFG_W = 64;
   // excluded groups: power preference, interface, time/date format
   localparam logic [CFG_W-1:0] CFG_KEEP_MASK = 64'hff00_0000_0000_0000;
   localparam logic [CFG_W-1:0] CFG_FACTORY = 64'h0000_0000_0000_0000;
   localparam logic [3:0] STORE_FACTORY = 4'h0;
   localparam logic [3:0] STORE_FIRST = 4'h1;
   localparam logic [3:0] STORE_LAST = 4'ha;
   // completion flag word layout
   localparam int FLG_NONHARM_LSB = 0;
   localparam int FLG_MOTOR = 3;
   localparam int FLG_HARM_LSB = 8;
   localparam int FLG_SPECTRUM = 16;
   localparam logic [31:0] FLAGS_RESET = 32'h0000_0000;
   // reply codes
   localparam logic [31:0] ACC_C_IDLE = 32'h0;
   localparam logic [31:0] ACC_C_WAIT = 32'h1;
   localparam logic [31:0] ACC_C_HELD = 32'h2;
   localparam logic [31:0] ACC_C_RUN = 32'h3;
   localparam logic [31:0] SC_C_STOP_EMPTY = 32'h0;
   localparam logic [31:0] SC_C_STOP_DATA = 32'h1;
   localparam logic [31:0] SC_C_SINGLE = 32'h2;
   localparam logic [31:0] SC_C_CONT_EMPTY = 32'h3;
   localparam logic [31:0] SC_C_CONT_DATA = 32'h4;
   localparam logic [31:0] SB_C_NONE = 32'h0;
   localparam logic [31:0] SB_C_USER = 32'h1;
   localparam logic [31:0] SB_C_NORM = 32'h2;
   localparam logic [31:0] SB_C_WAIT = 32'h3;
   localparam logic [31:0] SB_C_MIN = 32'h4;
   localparam logic [31:0] SB_C_EXT = 32'h5;
   localparam logic [31:0] SB_C_ALT = 32'h6;
   // reply text
   localparam logic [7:0] RSP_TERM = 8'h0a;
   localparam logic [7:0] ASCII_ZERO = 8'h30;
   localparam int DIG_N = 10;
   typedef enum logic [1:0] {ACC_IDLE, ACC_WAIT, ACC_RUN} mrsc_acc_t;
   typedef enum logic [1:0] {SC_STOP, SC_SINGLE, SC_CONT} mrsc_scope_t;
   typedef enum logic [2:0] {SB_NONE, SB_USER, SB_NORM, SB_WAIT, SB_MIN, SB_EXT, SB_ALT} mrsc_sb_t;
   typedef enum logic [1:0] {F_IDLE, F_DIV, F_EMIT, F_TERM} mrsc_fmt_t;
endpackage : mrsc_pkg

/* core/mrsc_reply_fmt.sv */
// unsigned value to decimal text with terminator
`timescale 1ns/1ps
`default_nettype none
module mrsc_reply_fmt
   import mrsc_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic start,
   input wire logic [31:0] value,
   output logic idle,
   output logic rsp_valid,
   input wire logic rsp_ready,
   output logic [7:0] rsp_data
);
   mrsc_fmt_t st_ff;
   logic [31:0] val_ff;
   logic [3:0] dig_ff [DIG_N];
   logic [3:0] cnt_ff;
   logic [7:0] byte_ff;
   logic [31:0] quot;
   logic [3:0] rem;

   assign quot = val_ff / 32'd10;
   assign rem = 4'(val_ff - quot * 32'd10);
   assign idle = (st_ff == F_IDLE);
   assign rsp_valid = (st_ff == F_EMIT) || (st_ff == F_TERM);
   assign rsp_data = byte_ff;

   // least digit first, so no leading zeros can arise
   always_ff @(posedge clk_sys)
   begin
      if (!rstn)
      begin
         st_ff <= F_IDLE;
         val_ff <= 32'h0;
         cnt_ff <= 4'h0;
         byte_ff <= 8'h00;
      end
      else
      begin
         unique case (st_ff)
            F_IDLE:
               if (start)
               begin
                  val_ff <= value;
                  cnt_ff <= 4'h0;
                  st_ff <= F_DIV;
               end
            F_DIV:
            begin
               dig_ff[cnt_ff] <= rem;
               val_ff <= quot;
               cnt_ff <= cnt_ff + 4'h1;
               if (quot == 32'h0)
               begin
                  byte_ff <= ASCII_ZERO + {4'h0, rem};
                  st_ff <= F_EMIT;
               end
            end
            F_EMIT:
               if (rsp_ready)
               begin
                  if (cnt_ff == 4'h1)
                  begin
                     byte_ff <= RSP_TERM;
                     st_ff <= F_TERM;
                  end
                  else
                  begin
                     byte_ff <= ASCII_ZERO + {4'h0, dig_ff[cnt_ff - 4'h2]};
                     cnt_ff <= cnt_ff - 4'h1;
                  end
               end
            F_TERM:
               if (rsp_ready)
                  st_ff <= F_IDLE;
         endcase
      end
   end
endmodule : mrsc_reply_fmt
`default_nettype wire

/* core/mrsc_cfg_store.sv */
// ten user configuration stores plus read-only factory store
`timescale 1ns/1ps
`default_nettype none
module mrsc_cfg_store
   import mrsc_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic save_req,
   input wire logic recall_req,
   input wire logic [3:0] idx,
   input wire logic [CFG_W-1:0] wdata,
   output logic [CFG_W-1:0] rdata,
   output logic rd_ok,
   output logic op_err
);
   logic [CFG_W-1:0] mem [1:10];
   logic [10:1] used_ff;
   logic user_idx;

   assign user_idx = (idx >= STORE_FIRST) && (idx <= STORE_LAST);

   always_ff @(posedge clk_sys)
   begin
      if (save_req && user_idx)
         mem[idx] <= wdata;
   end

   always_ff @(posedge clk_sys)
   begin
      if (!rstn)
         used_ff <= '0;
      else if (save_req && user_idx)
         used_ff[idx] <= 1'b1;
   end

   always_ff @(posedge clk_sys)
   begin
      if (!rstn)
      begin
         rdata <= CFG_FACTORY;
         rd_ok <= 1'b0;
         op_err <= 1'b0;
      end
      else
      begin
         rd_ok <= 1'b0;
         op_err <= 1'b0;
         if (save_req && !user_idx)
            op_err <= 1'b1;
         else if (recall_req && idx == STORE_FACTORY)
         begin
            rdata <= CFG_FACTORY;
            rd_ok <= 1'b1;
         end
         else if (recall_req && user_idx && used_ff[idx])
         begin
            rdata <= mem[idx];
            rd_ok <= 1'b1;
         end
         else if (recall_req)
            op_err <= 1'b1;
      end
   end
endmodule : mrsc_cfg_store
`default_nettype wire

/* dv/mrsc_checker.sv */
// assertion checker for the run/status command block
`timescale 1ns/1ps
`default_nettype none
module mrsc_checker
   import mrsc_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic cmd_valid,
   input wire logic cmd_ready,
   input wire logic [3:0] cmd_code,
   input wire logic [3:0] cmd_arg,
   input wire logic [1:0] cmd_sel,
   input wire logic cmd_err,
   input wire logic rsp_valid,
   input wire logic rsp_ready,
   input wire logic [7:0] rsp_data,
   input wire logic meas_frozen,
   input wire logic acc_clear,
   input wire logic acc_updating,
   input wire logic scope_discard,
   input wire logic scope_running,
   input wire logic [NVPA-1:0] stby_active
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rstn);
   wire logic take;
   assign take = cmd_valid && cmd_ready;
   chk_freeze_on: assert property (
      take && cmd_code == CMD_FREEZE && cmd_arg == 4'h1 |=> meas_frozen)
      else $error("freeze not applied");
   chk_freeze_off: assert property (
      take && cmd_code == CMD_FREEZE && cmd_arg == 4'h0 |=> !meas_frozen)
      else $error("freeze not released");
   chk_acc_restart: assert property (
      take && cmd_code == CMD_ACC_RUN && cmd_arg == 4'h1 |=> acc_clear ##1 !acc_clear)
      else $error("accumulation clear pulse wrong");
   chk_acc_stop: assert property (
      take && cmd_code == CMD_ACC_RUN && cmd_arg == 4'h0 |=> !acc_updating && !acc_clear)
      else $error("accumulation did not stop");
   chk_frozen_hold: assert property (
      meas_frozen |-> !acc_updating)
      else $error("accumulation updating while frozen");
   chk_scope_start: assert property (
      take && cmd_code == CMD_SCOPE && cmd_arg inside {4'h1, 4'h2}
      |=> scope_discard && scope_running)
      else $error("capture start wrong");
   chk_scope_stop: assert property (
      take && cmd_code == CMD_SCOPE && cmd_arg == 4'h0 |=> !scope_running && !scope_discard)
      else $error("capture stop wrong");
   chk_stby_start: assert property (
      take && cmd_code == CMD_STBY_RUN && cmd_arg == 4'h1 && cmd_sel != 2'h3
      |=> stby_active[$past(cmd_sel)])
      else $error("standby run not started");
   chk_save_range: assert property (
      take && cmd_code == CMD_SAVE && (cmd_arg == 4'h0 || cmd_arg > STORE_LAST)
      |-> ##[1:3] cmd_err)
      else $error("bad save index accepted");
   chk_reply_hold: assert property (
      rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp_data))
      else $error("reply byte dropped");
   cover property (take && cmd_code == CMD_RECALL);
   cover property (rsp_valid && rsp_ready && rsp_data == RSP_TERM);
   cover property (acc_updating);
endmodule : mrsc_checker
bind mrsc_top mrsc_checker u_chk (.*);
`default_nettype wire

/* dv/mrsc_host.sv */
// remote host model: takes reply bytes with stalls, decodes decimal text
`timescale 1ns/1ps
`default_nettype none
module mrsc_host
   import mrsc_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rsp_valid,
   input wire logic [7:0] rsp_data,
   output logic rsp_ready,
   output logic done,
   output logic [31:0] val,
   output logic bad
);
   logic [31:0] acc = 32'h0;
   logic e = 1'b0;
   int n = 0;
   initial rsp_ready = 1'b0;
   initial done = 1'b0;
   always @(posedge clk_sys) rsp_ready <= #1 ($urandom_range(3) != 0);
   always @(posedge clk_sys)
   begin
      done <= 1'b0;
      if (rsp_valid === 1'b1 && rsp_ready === 1'b1)
      begin
         if (rsp_data === RSP_TERM)
         begin
            done <= 1'b1;
            val <= acc;
            bad <= (n == 0) || e;
            acc = 32'h0;
            n = 0;
            e = 1'b0;
         end
         else
         begin
            e = e || (n > 0 && acc == 0) || rsp_data < ASCII_ZERO || rsp_data > 8'h39;
            acc = acc * 10 + 32'(rsp_data - ASCII_ZERO);
            n++;
         end
      end
   end
endmodule : mrsc_host
`default_nettype wire

/* dv/testbench.sv */
// self-checking bench for the run/status command block
`timescale 1ns/1ps
`default_nettype none
module testbench
   import mrsc_pkg::*;
;
   logic clk_sys = 1'b0;
   logic rstn, cmd_valid, cmd_ready, cmd_err, rsp_valid, rsp_ready, meas_frozen;
   logic [3:0] cmd_code, cmd_arg;
   logic [1:0] cmd_sel, s;
   logic [CFG_W-1:0] cfg_edit, cfg_active, cur;
   logic [CFG_W-1:0] st [1:10];
   logic [7:0] rsp_data;
   logic [NVPA-1:0] ev_nonharm_done, ev_harm_done, stby_alt_method, stby_level_seen;
   logic [NVPA-1:0] stby_min_elapsed, stby_finished, stby_active;
   logic ev_motor_done, ev_spectrum_done, acc_clear, acc_updating;
   logic scope_captured, scope_discard, scope_running, done, bad;
   logic [15:0] acc_delay_cyc;
   logic [31:0] val, fexp;
   logic [31:0] exp_q [$];
   int error_cnt = 0;
   int samples_checked = 0;
   int cyc = 0;
   int m;
   mrsc_top u_dut (.*);
   mrsc_host u_host (.*);
   always #25 clk_sys = ~clk_sys;
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic tally_and_finish;
      $display("checks %0d errors %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : tally_and_finish
   task automatic tick;
      @(posedge clk_sys);
      #1;
   endtask : tick
   task automatic cmd(input logic [3:0] c, input logic [3:0] a, input logic [1:0] sl,
      input logic e);
      logic err;
      err = 1'b0;
      tick;
      cmd_code = c;
      cmd_arg = a;
      cmd_sel = sl;
      cmd_valid = 1'b1;
      do @(posedge clk_sys); while (cmd_ready !== 1'b1);
      #1 cmd_valid = 1'b0;
      repeat (3)
      begin
         @(posedge clk_sys);
         err = err | cmd_err;
      end
      #1;
      check(64'(err), 64'(e));
   endtask : cmd
   task automatic qry(input logic [3:0] c, input logic [1:0] sl, input logic [31:0] e);
      exp_q.push_back(e);
      cmd(c, 4'h0, sl, 1'b0);
   endtask : qry
   task automatic events;
      repeat (3)
      begin
         {ev_nonharm_done, ev_harm_done, ev_motor_done, ev_spectrum_done} = 8'($urandom);
         fexp |= {15'h0, ev_spectrum_done, 5'h0, ev_harm_done, 4'h0, ev_motor_done,
            ev_nonharm_done};
         tick;
      end
      {ev_nonharm_done, ev_harm_done, ev_motor_done, ev_spectrum_done} = 8'h0;
   endtask : events
   always @(posedge clk_sys)
   begin
      if (done === 1'b1)
      begin
         if (exp_q.size() == 0)
            check(64'h1, 64'h0);
         else
            check(64'(val), 64'(exp_q.pop_front()));
         check(64'(bad), 64'h0);
      end
      cyc++;
      if (cyc == 20000)
      begin
         error_cnt++;
         tally_and_finish;
      end
   end
   initial
   begin
      {rstn, cmd_valid, cmd_code, cmd_arg, cmd_sel, scope_captured} = '0;
      {ev_nonharm_done, ev_harm_done, ev_motor_done, ev_spectrum_done} = 8'h0;
      {stby_alt_method, stby_level_seen, stby_min_elapsed, stby_finished} = '0;
      cfg_edit = '0;
      acc_delay_cyc = 16'h0;
      void'($urandom(32'h3d5b6b98));
      repeat (3) tick;
      rstn = 1'b1;
      qry(CMD_FREEZE_Q, 2'h0, 32'h0);
      cmd(4'hc, 4'h0, 2'h0, 1'b1);
      acc_delay_cyc = 16'(200 + $urandom_range(40));
      cmd(CMD_ACC_RUN, 4'h1, 2'h0, 1'b0);
      qry(CMD_ACC_Q, 2'h0, ACC_C_WAIT);
      repeat (acc_delay_cyc) tick;
      qry(CMD_ACC_Q, 2'h0, ACC_C_RUN);
      cmd(CMD_FREEZE, 4'h1, 2'h0, 1'b0);
      check(64'(meas_frozen), 64'h1);
      qry(CMD_FREEZE_Q, 2'h0, 32'h1);
      qry(CMD_ACC_Q, 2'h0, ACC_C_HELD);
      cmd(CMD_FREEZE, 4'h2, 2'h0, 1'b1);
      cmd(CMD_FREEZE, 4'h0, 2'h0, 1'b0);
      qry(CMD_FREEZE_Q, 2'h0, 32'h0);
      qry(CMD_ACC_Q, 2'h0, ACC_C_RUN);
      cmd(CMD_ACC_RUN, 4'h0, 2'h0, 1'b0);
      qry(CMD_ACC_Q, 2'h0, ACC_C_IDLE);
      acc_delay_cyc = 16'h0;
      cmd(CMD_ACC_RUN, 4'h1, 2'h0, 1'b0);
      qry(CMD_ACC_Q, 2'h0, ACC_C_RUN);
      cmd(CMD_ACC_RUN, 4'h0, 2'h0, 1'b0);
      fexp = 32'h0;
      events;
      qry(CMD_FLAG_RD, 2'h0, fexp);
      qry(CMD_FLAG_RD, 2'h0, 32'h0);
      fexp = 32'h0;
      events;
      cmd(CMD_COMMIT, 4'h0, 2'h0, 1'b0);
      qry(CMD_FLAG_RD, 2'h0, fexp);
      fexp = 32'h0;
      events;
      cfg_edit = {$urandom, $urandom};
      cmd(CMD_COMMIT, 4'h0, 2'h0, 1'b0);
      qry(CMD_FLAG_RD, 2'h0, 32'h0);
      qry(CMD_SCOPE_Q, 2'h0, SC_C_STOP_EMPTY);
      for (m = 1; m <= 2; m++)
      begin
         cmd(CMD_SCOPE, 4'(m), 2'h0, 1'b0);
         qry(CMD_SCOPE_Q, 2'h0, m == 1 ? SC_C_SINGLE : SC_C_CONT_EMPTY);
         scope_captured = 1'b1;
         tick;
         scope_captured = 1'b0;
         qry(CMD_SCOPE_Q, 2'h0, m == 1 ? SC_C_STOP_DATA : SC_C_CONT_DATA);
      end
      cmd(CMD_SCOPE, 4'h0, 2'h0, 1'b0);
      qry(CMD_SCOPE_Q, 2'h0, SC_C_STOP_DATA);
      cmd(CMD_SCOPE, 4'h3, 2'h0, 1'b1);
      s = 2'($urandom_range(2));
      qry(CMD_STBY_Q, s, SB_C_NONE);
      for (m = 0; m < 2; m++)
      begin
         stby_alt_method[s] = m[0];
         cmd(CMD_STBY_RUN, 4'h1, s, 1'b0);
         qry(CMD_STBY_Q, s, m ? SB_C_WAIT : SB_C_MIN);
         stby_level_seen[s] = m[0];
         stby_min_elapsed[s] = !m[0];
         tick;
         {stby_level_seen, stby_min_elapsed} = '0;
         qry(CMD_STBY_Q, s, m ? SB_C_ALT : SB_C_EXT);
         stby_finished[s] = m[0];
         tick;
         stby_finished = '0;
         if (m == 0)
            cmd(CMD_STBY_RUN, 4'h0, s, 1'b0);
         qry(CMD_STBY_Q, s, m ? SB_C_NORM : SB_C_USER);
      end
      cmd(CMD_STBY_RUN, 4'h1, 2'h3, 1'b1);
      cmd(CMD_STBY_Q, 4'h0, 2'h3, 1'b1);
      cmd(CMD_SAVE, 4'h0, 2'h0, 1'b1);
      cmd(CMD_SAVE, 4'hb, 2'h0, 1'b1);
      cmd(CMD_RECALL, 4'h5, 2'h0, 1'b1);
      check(cfg_active, cfg_edit);
      for (m = 1; m <= 10; m++)
      begin
         cfg_edit = {$urandom, $urandom};
         st[m] = cfg_edit;
         cmd(CMD_COMMIT, 4'h0, 2'h0, 1'b0);
         cmd(CMD_SAVE, 4'(m), 2'h0, 1'b0);
      end
      cur = cfg_edit;
      for (m = 10; m >= 1; m--)
      begin
         cmd(CMD_RECALL, 4'(m), 2'h0, 1'b0);
         check(cfg_active, (cur & CFG_KEEP_MASK) | (st[m] & ~CFG_KEEP_MASK));
      end
      cmd(CMD_RECALL, STORE_FACTORY, 2'h0, 1'b0);
      check(cfg_active, (cur & CFG_KEEP_MASK) | (CFG_FACTORY & ~CFG_KEEP_MASK));
      repeat (40) tick;
      check(64'(exp_q.size()), 64'h0);
      tally_and_finish;
   end
endmodule : testbench
`default_nettype wire
